// ===== include/chan_io_pkg.sv
// Notes on behaviour
// - power request goes low after enumeration, high again in suspend
// - with pull-down enabled, io lines pulled low while power is off
// - wake pin strobe in suspend with remote wake on requests resume
// - wake pin strobe when awake flushes receive data on next bulk in
// - flush timeout set in 1 ms steps from 1 to 255 ms
// - baud divisor has a fraction of zero to seven eighths
// - integer divisor accepts any value from 2 to 16384
// - bit-bang modes turn the eight data lines into a parallel port
// - async bit-bang sends buffered bytes one per baud timer period
// - read and write strobes are driven out on each port access
// - sync bit-bang samples pins only when a byte is written
// - external reset input drives reset output low; block itself is not reset
// - enumeration held off until clock settle check reports stable
// - mode code 0 normal, 1 async bit-bang, 4 sync bit-bang
// - baud tick is sixteen times oversampling, 14-bit plus 3 fraction
package chan_io_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_BAUD   = 12'h004;
  localparam logic [11:0] ADDR_FLUSH  = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_TXDATA = 12'h010;
  localparam logic [11:0] ADDR_RXDATA = 12'h014;
  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PD_BIT   = 8;
  localparam int CTRL_WAKE_BIT = 9;
  localparam int CTRL_DIR_LSB  = 16;
  localparam int BAUD_FRAC_LSB = 14;
  localparam int RX_VALID_BIT  = 8;
  localparam int ST_POWER_BIT  = 0;
  localparam int ST_SUSP_BIT   = 1;
  localparam int ST_CLKOK_BIT  = 2;
  localparam int ST_RESET_OUT_N_BIT = 3;
  localparam int ST_TXFULL_BIT = 4;
  localparam int ST_RXVAL_BIT  = 5;
  localparam int ST_PEND_BIT   = 6;
  localparam int ST_PINS_LSB   = 8;
  // ---------------------------------------------------------------
  // mode codes and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  MODE_CODE_NORMAL = 8'h00;
  localparam logic [7:0]  MODE_CODE_ASYNC  = 8'h01;
  localparam logic [7:0]  MODE_CODE_SYNC   = 8'h04;
  localparam logic [13:0] BAUD_INT_RST     = 14'h001a;
  localparam logic [2:0]  BAUD_FRAC_RST    = 3'h0;
  localparam logic [7:0]  FLUSH_MS_RST     = 8'h10;
  localparam logic [7:0]  FLUSH_MS_MIN     = 8'h01;
  localparam logic [14:0] DIV_MIN          = 15'h0002;
  localparam logic [14:0] DIV_MAX          = 15'h4000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FLUSH_STEP_NS = 1000000;
  localparam int MS_CYCLES     = FLUSH_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {M_NORMAL, M_ASYNC, M_SYNC} mode_t;
endpackage

// ===== design/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import chan_io_pkg::*;
#(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pin side
  input  wire logic [W-1:0] d,
  // settled level and falling edges
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] stable_ff;
  logic [W-1:0] fall_ff;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff     <= INIT;
      s2_ff     <= INIT;
      s3_ff     <= INIT;
      stable_ff <= INIT;
      fall_ff   <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          stable_ff[i] <= s3_ff[i];
        end
        fall_ff[i] <= (s2_ff[i] == s3_ff[i]) & ~s3_ff[i] & stable_ff[i];
      end
    end
  end

  assign level = stable_ff;
  assign fall  = fall_ff;
endmodule
`default_nettype wire

// ===== design/pair_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module pair_buffer
  import chan_io_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem [2];
  logic         wptr_ff;
  logic         rptr_ff;
  logic [1:0]   cnt_ff;
  logic         push;
  logic         pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data  = mem[rptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset; only occupied slots are ever read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr_ff] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff <= 1'b0;
      rptr_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end else begin
      if (push) wptr_ff <= ~wptr_ff;
      if (pop)  rptr_ff <= ~rptr_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ===== design/chan_io_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module chan_io_ctrl
  import chan_io_pkg::*;
#(
  parameter int MS_LEN = MS_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // usb engine
  input  wire logic        usb_enumerated,
  input  wire logic        usb_suspended,
  input  wire logic        rx_buf_pending,
  output logic             usb_enum_enable,
  output logic             usb_resume_req,
  output logic             usb_flush_req,
  output logic             baud_x16_tick,
  // power, reset and wake pins
  output logic             power_on_request_n,
  output logic             io_pull_down,
  input  wire logic        send_now_wake_pin,
  input  wire logic        ext_reset_n,
  output logic             reset_out_n,
  input  wire logic        clock_settle_check,
  // parallel port
  input  wire logic [7:0]  port_in,
  output logic      [7:0]  port_out,
  output logic      [7:0]  port_oe,
  output logic             rd_strobe_n,
  output logic             wr_strobe_n
);
  localparam int MSW = $clog2(MS_LEN + 1);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_BAUD) ||
              (a == ADDR_FLUSH) || (a == ADDR_STATUS) ||
              (a == ADDR_TXDATA) || (a == ADDR_RXDATA);
  endfunction

  function automatic logic [7:0] mode_code(input mode_t m);
    unique case (m)
      M_ASYNC:  mode_code = MODE_CODE_ASYNC;
      M_SYNC:   mode_code = MODE_CODE_SYNC;
      M_NORMAL: mode_code = MODE_CODE_NORMAL;
      default:  mode_code = MODE_CODE_NORMAL;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic       wake_fall;
  logic       rst_lvl;
  logic       clk_ok;
  logic [7:0] pins;

  pin_sync #(.W(1), .INIT(1'b1)) u_wake (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (send_now_wake_pin),
    .level   (),
    .fall    (wake_fall)
  );
  pin_sync #(.W(1), .INIT(1'b0)) u_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (ext_reset_n),
    .level   (rst_lvl),
    .fall    ()
  );
  pin_sync #(.W(1), .INIT(1'b0)) u_clk (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (clock_settle_check),
    .level   (clk_ok),
    .fall    ()
  );
  pin_sync #(.W(8), .INIT(8'h00)) u_port (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (port_in),
    .level   (pins),
    .fall    ()
  );

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic        ready_ff;
  logic        err_ff;
  logic [31:0] rdata_ff;
  logic        go;
  logic        fire;
  logic        wr_ok;
  logic        tx_in_ready;
  logic        tx_out_valid;
  logic [7:0]  tx_data;
  logic        tx_pop;
  mode_t       mode_ff;
  logic        pd_en_ff;
  logic        wake_en_ff;
  logic [7:0]  dir_ff;
  logic [13:0] div_int_ff;
  logic [2:0]  div_frac_ff;
  logic [7:0]  flush_ms_ff;
  logic        pwr_n_ff;
  logic        rst_out_ff;
  logic [7:0]  rx_data_ff;
  logic        rx_valid_ff;
  logic [31:0] nxt_rdata;

  // a tx write waits while the pair buffer is full: back-pressure
  assign go = psel & penable & ~ready_ff &
              (~(pwrite & (paddr == ADDR_TXDATA)) | tx_in_ready);
  assign fire  = psel & penable & ready_ff;
  assign wr_ok = fire & pwrite & ~err_ff;

  // read mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL: begin
        nxt_rdata[CTRL_MODE_LSB +: 8] = mode_code(mode_ff);
        nxt_rdata[CTRL_PD_BIT]        = pd_en_ff;
        nxt_rdata[CTRL_WAKE_BIT]      = wake_en_ff;
        nxt_rdata[CTRL_DIR_LSB +: 8]  = dir_ff;
      end
      ADDR_BAUD: begin
        nxt_rdata[13:0]                 = div_int_ff;
        nxt_rdata[BAUD_FRAC_LSB +: 3]   = div_frac_ff;
      end
      ADDR_FLUSH: nxt_rdata[7:0] = flush_ms_ff;
      ADDR_STATUS: begin
        nxt_rdata[ST_POWER_BIT]      = ~pwr_n_ff;
        nxt_rdata[ST_SUSP_BIT]       = usb_suspended;
        nxt_rdata[ST_CLKOK_BIT]      = clk_ok;
        nxt_rdata[ST_RESET_OUT_N_BIT]     = rst_out_ff;
        nxt_rdata[ST_TXFULL_BIT]     = ~tx_in_ready;
        nxt_rdata[ST_RXVAL_BIT]      = rx_valid_ff;
        nxt_rdata[ST_PEND_BIT]       = rx_buf_pending;
        nxt_rdata[ST_PINS_LSB +: 8]  = pins;
      end
      ADDR_RXDATA: begin
        nxt_rdata[7:0]          = rx_data_ff;
        nxt_rdata[RX_VALID_BIT] = rx_valid_ff;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // one wait state, answer from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ready_ff <= go;
      err_ff   <= go & ~addr_ok(paddr);
      if (go) rdata_ff <= nxt_rdata;
    end
  end

  assign pready  = ready_ff;
  assign pslverr = err_ff;
  assign prdata  = rdata_ff;

  // control registers; unknown mode codes fall back to normal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff     <= M_NORMAL;
      pd_en_ff    <= 1'b0;
      wake_en_ff  <= 1'b0;
      dir_ff      <= 8'h00;
      div_int_ff  <= BAUD_INT_RST;
      div_frac_ff <= BAUD_FRAC_RST;
      flush_ms_ff <= FLUSH_MS_RST;
    end else if (wr_ok) begin
      if (paddr == ADDR_CTRL) begin
        unique case (pwdata[CTRL_MODE_LSB +: 8])
          MODE_CODE_ASYNC: mode_ff <= M_ASYNC;
          MODE_CODE_SYNC:  mode_ff <= M_SYNC;
          default:         mode_ff <= M_NORMAL;
        endcase
        pd_en_ff   <= pwdata[CTRL_PD_BIT];
        wake_en_ff <= pwdata[CTRL_WAKE_BIT];
        dir_ff     <= pwdata[CTRL_DIR_LSB +: 8];
      end
      if (paddr == ADDR_BAUD) begin
        div_int_ff  <= pwdata[13:0];
        div_frac_ff <= pwdata[BAUD_FRAC_LSB +: 3];
      end
      if (paddr == ADDR_FLUSH) begin
        flush_ms_ff <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // power, reset and enumeration
  // ---------------------------------------------------------------
  logic enum_en_ff;

  // reset out only released with external reset high and clock settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_n_ff   <= 1'b1;
      rst_out_ff <= 1'b0;
      enum_en_ff <= 1'b0;
    end else begin
      pwr_n_ff   <= ~(usb_enumerated & ~usb_suspended);
      rst_out_ff <= rst_lvl & clk_ok;
      enum_en_ff <= clk_ok & rst_out_ff;
    end
  end

  assign power_on_request_n = pwr_n_ff;
  assign io_pull_down       = pd_en_ff & pwr_n_ff;
  assign reset_out_n        = rst_out_ff;
  assign usb_enum_enable    = enum_en_ff;

  // ---------------------------------------------------------------
  // wake, send-now and flush timeout
  // ---------------------------------------------------------------
  logic [MSW-1:0] ms_cnt_ff;
  logic [7:0]     elapsed_ff;
  logic           resume_ff;
  logic           flush_ff;
  logic           ms_tick;
  logic           expire;
  logic           flush_now;
  logic [7:0]     limit;

  // a zero setting would mean no timeout; clamp to the 1 ms floor
  assign limit = (flush_ms_ff < FLUSH_MS_MIN) ? FLUSH_MS_MIN
                                              : flush_ms_ff;
  assign ms_tick   = (ms_cnt_ff == MSW'(MS_LEN - 1));
  assign expire    = ms_tick & ((elapsed_ff + 8'h01) >= limit);
  assign flush_now = (wake_fall & ~usb_suspended) | expire;

  // ms counter only runs while receive data waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_ff  <= '0;
      elapsed_ff <= 8'h00;
    end else if (~rx_buf_pending | flush_now) begin
      ms_cnt_ff  <= '0;
      elapsed_ff <= 8'h00;
    end else if (ms_tick) begin
      ms_cnt_ff  <= '0;
      elapsed_ff <= elapsed_ff + 8'h01;
    end else begin
      ms_cnt_ff  <= ms_cnt_ff + MSW'(1);
    end
  end

  // request pulses to the usb engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_ff <= 1'b0;
      flush_ff  <= 1'b0;
    end else begin
      resume_ff <= wake_fall & usb_suspended & wake_en_ff;
      flush_ff  <= flush_now;
    end
  end

  assign usb_resume_req = resume_ff;
  assign usb_flush_req  = flush_ff;

  // ---------------------------------------------------------------
  // fractional baud timer
  // ---------------------------------------------------------------
  logic [14:0] cnt_ff;
  logic [2:0]  acc_ff;
  logic [14:0] div_n;
  logic [3:0]  nxt_acc;
  logic        tick;

  // field 0 means 2^14; 1 is raised to the legal minimum
  assign div_n = (div_int_ff == 14'h0000) ? DIV_MAX :
                 (div_int_ff == 14'h0001) ? DIV_MIN :
                 {1'b0, div_int_ff};
  assign nxt_acc = {1'b0, acc_ff} + {1'b0, div_frac_ff};
  assign tick    = (cnt_ff == 15'h0000);

  // fraction carry stretches a period by one cycle in eighths
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 15'h0000;
      acc_ff <= 3'h0;
    end else if (tick) begin
      acc_ff <= nxt_acc[2:0];
      cnt_ff <= div_n - 15'h0001 + {14'h0000, nxt_acc[3]};
    end else begin
      cnt_ff <= cnt_ff - 15'h0001;
    end
  end

  assign baud_x16_tick = tick;

  // ---------------------------------------------------------------
  // bit-bang engine
  // ---------------------------------------------------------------
  logic [7:0] out_ff;
  logic [7:0] oe_ff;
  logic       wr_n_ff;
  logic       rd_n_ff;
  logic       sample;
  logic       rx_clr;

  pair_buffer #(.W(8)) u_txbuf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (wr_ok & (paddr == ADDR_TXDATA)),
    .in_ready  (tx_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_data)
  );

  // one byte per timer period, only in a bit-bang mode
  assign tx_pop = tx_out_valid & tick & (mode_ff != M_NORMAL);
  assign sample = (mode_ff == M_ASYNC) ? tick :
                  (mode_ff == M_SYNC)  ? tx_pop : 1'b0;
  // clear on the capture edge, so a sample landing later is never lost
  assign rx_clr = go & ~pwrite & (paddr == ADDR_RXDATA);

  // port drive and strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff  <= 8'h00;
      oe_ff   <= 8'h00;
      wr_n_ff <= 1'b1;
      rd_n_ff <= 1'b1;
    end else begin
      oe_ff   <= (mode_ff == M_NORMAL) ? 8'h00 : dir_ff;
      wr_n_ff <= ~tx_pop;
      rd_n_ff <= ~sample;
      if (tx_pop) out_ff <= tx_data;
    end
  end

  // read capture; a new sample beats a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else if (sample) begin
      rx_data_ff  <= pins;
      rx_valid_ff <= 1'b1;
    end else if (rx_clr) begin
      rx_valid_ff <= 1'b0;
    end
  end

  assign port_out    = out_ff;
  assign port_oe     = oe_ff;
  assign wr_strobe_n = wr_n_ff;
  assign rd_strobe_n = rd_n_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  power_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    usb_suspended |=> power_on_request_n)
    else $error("power request not dropped in suspend");
  pull_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pd_en_ff && ($past(usb_suspended) || !$past(usb_enumerated)))
      |-> io_pull_down)
    else $error("pull-down missing while power off");
  wake_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_fall && usb_suspended && wake_en_ff) |=> usb_resume_req)
    else $error("wake strobe gave no resume request");
  send_now_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_fall && !usb_suspended) |=> usb_flush_req && !usb_resume_req)
    else $error("send-now strobe gave no flush");
  baud_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    baud_x16_tick |=> !baud_x16_tick)
    else $error("baud ticks closer than two cycles");
  port_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_ff == M_NORMAL) |=> (port_oe == 8'h00))
    else $error("port driven in normal mode");
  wr_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_pop |=> !wr_strobe_n && (port_out == $past(tx_data)))
    else $error("write strobe or data missing");
  sync_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(mode_ff) == M_SYNC && !rd_strobe_n) |-> !wr_strobe_n)
    else $error("sync mode read without write");
  enum_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_ok |=> !usb_enum_enable)
    else $error("enumeration enabled before clock settled");
  rst_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rst_lvl |=> !reset_out_n ##1 !usb_enum_enable)
    else $error("reset out not driven low");
endmodule
`default_nettype wire

// ===== sim/port_logic_model.sv
`timescale 1ns/1ns
`default_nettype none
module port_logic_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // device side of the port
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe,
  input  wire logic       wr_strobe_n,
  // pins and our own driven value
  output logic      [7:0] port_in,
  output logic      [7:0] drv_val
);
  // external logic clocked by the write strobe steps its answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_val <= 8'h3c;
    end else if (!wr_strobe_n) begin
      drv_val <= drv_val + 8'h11;
    end
  end
  // bits the device drives win, the rest carry our value
  assign port_in = (port_out & port_oe) | (drv_val & ~port_oe);
endmodule
`default_nettype wire

// ===== sim/channel_io_flush_bitbang_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module channel_io_flush_bitbang_ctrl_tb
  import chan_io_pkg::*;
;
  localparam int MSL = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        usb_enumerated, usb_suspended, rx_buf_pending, usb_enum_enable;
  logic        usb_resume_req, usb_flush_req, baud_x16_tick, power_on_request_n;
  logic        io_pull_down, send_now_wake_pin, ext_reset_n, reset_out_n;
  logic        clock_settle_check, rd_strobe_n, wr_strobe_n;
  logic [7:0]  port_in, port_out, port_oe, pval;
  logic [5:0]  mon;
  int          num_errors = 0;
  int          total_checks = 0;
  int          n, sum;

  // events watched by the wait task, one bit each
  assign mon = {reset_out_n, ~rd_strobe_n, ~wr_strobe_n, usb_flush_req,
                usb_resume_req, baud_x16_tick};

  chan_io_ctrl #(.MS_LEN(MSL)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usb_enumerated(usb_enumerated),
    .usb_suspended(usb_suspended), .rx_buf_pending(rx_buf_pending),
    .usb_enum_enable(usb_enum_enable), .usb_resume_req(usb_resume_req),
    .usb_flush_req(usb_flush_req), .baud_x16_tick(baud_x16_tick),
    .power_on_request_n(power_on_request_n), .io_pull_down(io_pull_down),
    .send_now_wake_pin(send_now_wake_pin), .ext_reset_n(ext_reset_n),
    .reset_out_n(reset_out_n), .clock_settle_check(clock_settle_check),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n));

  port_logic_model partner_u (.pclk(pclk), .presetn(presetn),
    .port_out(port_out), .port_oe(port_oe), .wr_strobe_n(wr_strobe_n),
    .port_in(port_in), .drv_val(pval));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // one apb transfer; holds everything until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 5000);
    rd = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 1, pready);
  endtask

  // bounded wait for one watched event, cycles waited in n
  task automatic wait_bit(input int i, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (mon[i] !== 1'b1 && n < lim);
    chk("event seen", 1, mon[i]);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power;
    step(20);
    chk("enum enable", 0, usb_enum_enable);
    chk("reset out", 0, reset_out_n);
    clock_settle_check <= 1'b1;
    wait_bit(5, 30);
    @(posedge pclk);
    #1;
    chk("enum enable", 1, usb_enum_enable);
    apb(1, ADDR_CTRL, 32'h00000100);
    step(3);
    chk("pull down", 1, io_pull_down);
    usb_enumerated <= 1'b1;
    step(3);
    chk("power req", 0, power_on_request_n);
    chk("pull down", 0, io_pull_down);
    usb_suspended <= 1'b1;
    step(3);
    chk("power req", 1, power_on_request_n);
    usb_suspended <= 1'b0;
    ext_reset_n <= 1'b0;
    step(6);
    chk("reset out", 0, reset_out_n);
    ext_reset_n <= 1'b1;
    wait_bit(5, 30);
    $display("power test done");
  endtask

  task automatic t_modes;
    logic [7:0] c [4] = '{8'h00, 8'h01, 8'h04, 8'h02};
    logic [7:0] e [4] = '{8'h00, 8'h01, 8'h04, 8'h00};
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_CTRL, {24'h0, c[i]});
      apb(0, ADDR_CTRL, 32'h0);
      chk("mode code", {24'h0, e[i]}, {24'h0, rd[7:0]});
    end
    apb(0, 12'hff0, 32'h0);
    chk("unmapped error", 1, lerr);
    chk("unmapped data", 0, rd);
    $display("mode test done");
  endtask

  task automatic t_baud;
    int iv [3] = '{2, 3, 4};
    int fv [3] = '{0, 7, 4};
    for (int i = 0; i < 3; i++) begin
      apb(1, ADDR_BAUD, 32'(fv[i] << 14) | 32'(iv[i]));
      wait_bit(0, 40);
      wait_bit(0, 40);
      sum = 0;
      repeat (8) begin
        wait_bit(0, 40);
        sum += n;
      end
      chk("eight tick span", 8 * iv[i] + fv[i], sum);
    end
    $display("baud test done");
  endtask

  task automatic t_buffer;
    apb(1, ADDR_CTRL, 32'h0);
    apb(1, ADDR_TXDATA, 32'ha5);
    apb(1, ADDR_TXDATA, 32'h3c);
    apb(0, ADDR_STATUS, 32'h0);
    chk("tx full", 1, rd[ST_TXFULL_BIT]);
    apb(1, ADDR_CTRL, 32'h00ff0001);
    wait_bit(3, 100);
    chk("port byte", 32'ha5, port_out);
    chk("port enable", 32'hff, port_oe);
    wait_bit(3, 100);
    chk("port byte", 32'h3c, port_out);
    wait_bit(4, 100);
    apb(0, ADDR_STATUS, 32'h0);
    chk("tx full", 0, rd[ST_TXFULL_BIT]);
    $display("buffer test done");
  endtask

  task automatic t_sync;
    logic [7:0] e;
    apb(1, ADDR_CTRL, 32'h00000004);
    apb(0, ADDR_RXDATA, 32'h0);
    e = pval;
    apb(1, ADDR_TXDATA, 32'h77);
    wait_bit(3, 100);
    chk("read with write", 0, rd_strobe_n);
    apb(0, ADDR_RXDATA, 32'h0);
    chk("sync sample", {23'h0, 1'b1, e}, rd);
    step(40);
    apb(0, ADDR_RXDATA, 32'h0);
    chk("no sample alone", 0, rd[RX_VALID_BIT]);
    $display("sync test done");
  endtask

  task automatic t_wake;
    apb(1, ADDR_CTRL, 32'h00000200);
    usb_suspended <= 1'b1;
    send_now_wake_pin <= 1'b0;
    wait_bit(1, 12);
    step(1);
    send_now_wake_pin <= 1'b1;
    usb_suspended <= 1'b0;
    step(6);
    send_now_wake_pin <= 1'b0;
    wait_bit(2, 12);
    step(1);
    send_now_wake_pin <= 1'b1;
    $display("wake test done");
  endtask

  task automatic t_flush;
    int ms [2] = '{1, 255};
    for (int i = 0; i < 2; i++) begin
      apb(1, ADDR_FLUSH, 32'(ms[i]));
      rx_buf_pending <= 1'b1;
      wait_bit(2, ms[i] * MSL + 10);
      wait_bit(2, ms[i] * MSL + 10);
      chk("flush gap", 1, n >= ms[i] * MSL && n <= ms[i] * MSL + 2);
      step(1);
      rx_buf_pending <= 1'b0;
    end
    $display("flush test done");
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {usb_enumerated, usb_suspended, rx_buf_pending} = '0;
    {send_now_wake_pin, ext_reset_n, clock_settle_check} = 3'b110;
    step(12);
    presetn <= 1'b1;
    t_power;
    t_modes;
    t_baud;
    t_buffer;
    t_sync;
    t_wake;
    t_flush;
    tally_and_finish;
  end

  // watchdog well past the expected run length
  initial begin
    #600000;
    num_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
